// File: rtl/pif_top.sv
// Peripheral interrupt flag and enable registers with an Avalon-MM slave.
// Assumes peripheral events are levels from other domains, held by the
// source at least two clocks; modulator flags are the modulators' own.
//
// What this block does
// - Flags set by events, ignoring all enables.
// - Modulator flags read-only, follow modulator sources.
// - Modulator flags at bits six, five, four.
// - Unimplemented flag and enable bits read zero.
// - Request flags reset to zero on reset.
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
module pif_top (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic [7:0] evt_first,
    input wire logic evt_comparator,
    input wire logic [2:0] modulator_pending_src,
    output logic periph_irq_req,
    output logic core_irq_req,
    output logic irq
);

    // =========================================================
    // State
    typedef struct packed {
        pif_pkg::pif_regs_t regs;
        pif_pkg::pif_bus_st_t bus;
        logic [7:0] evt_first_d;
        logic evt_cmp_d;
        logic [2:0] mod_flags;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic wait_n;
        logic periph_req;
        logic core_req;
        logic irq;
    } pif_state_t;

    pif_state_t st_r;
    pif_state_t st_nxt;

    // =========================================================
    // Input synchronisers
    logic [11:0] sync_out;
    pif_pkg::pif_src_t src;

    pif_sync #(
        .WIDTH(12)
    ) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .din({evt_first, evt_comparator, modulator_pending_src}),
        .dout(sync_out)
    );

    assign src = sync_out;

    // =========================================================
    // Edge detection
    // Every synchronised source bit gets the same rising-edge test against
    // its level of one clock earlier. Those earlier levels reset low, the
    // idle level of every source, so reset release never fakes an event.
    localparam int SRC_W = $bits(pif_pkg::pif_src_t);

    logic [SRC_W-1:0] src_prev;
    logic [SRC_W-1:0] src_rise;
    pif_pkg::pif_src_t src_edge;

    assign src_prev = {st_r.evt_first_d, st_r.evt_cmp_d, st_r.mod_flags};

    for (genvar i = 0; i < SRC_W; i++) begin : g_edge
        assign src_rise[i] = sync_out[i] & ~src_prev[i];
    end

    assign src_edge = src_rise;

    // =========================================================
    // Next-state logic
    logic [7:0] rise_first;
    logic rise_cmp;
    logic [7:0] req_mod_view;
    logic [7:0] pend_first;
    logic pend_cmp;
    logic [2:0] pend_mod;
    logic any_pend;
    logic new_flag;
    logic [2:0] ev;
    logic [31:0] rd;
    logic hit;
    logic do_wr;
    logic do_rd;
    logic [7:0] wb;

    always_comb begin
        st_nxt = st_r;
        rd = 32'h0000_0000;
        hit = 1'b1;
        wb = avs_writedata[7:0];
        do_wr = avs_write && st_r.bus == pif_pkg::BUS_IDLE
            && avs_byteenable[0];
        do_rd = avs_read && st_r.bus == pif_pkg::BUS_IDLE;

        st_nxt.evt_first_d = src.first;
        st_nxt.evt_cmp_d = src.cmp;
        // The modulator flags are copies only: no write reaches them, and
        // they clear when the modulator clears its own flags.
        st_nxt.mod_flags = src.mod;
        rise_first = src_edge.first & pif_pkg::MASK_FIRST;
        rise_cmp = src_edge.cmp;
        req_mod_view = {1'b0, st_r.mod_flags, 4'h0};

        // Register reads; unimplemented bits are masked to zero.
        case (avs_address)
            pif_pkg::OFS_REQ_FIRST:
                rd[7:0] = st_r.regs.req_first & pif_pkg::MASK_FIRST;
            pif_pkg::OFS_REQ_CMP:
                rd[7:0] = st_r.regs.req_cmp & pif_pkg::MASK_CMP;
            pif_pkg::OFS_REQ_MOD:
                rd[7:0] = req_mod_view & pif_pkg::MASK_MOD;
            pif_pkg::OFS_EN_FIRST:
                rd[7:0] = st_r.regs.en_first & pif_pkg::MASK_FIRST;
            pif_pkg::OFS_EN_SECOND:
                rd[7:0] = st_r.regs.en_second & pif_pkg::MASK_CMP;
            pif_pkg::OFS_EN_THIRD:
                rd[7:0] = st_r.regs.en_third & pif_pkg::MASK_MOD;
            pif_pkg::OFS_CORE_CTRL:
                rd[7:0] = st_r.regs.core_ctrl & pif_pkg::MASK_CTRL;
            pif_pkg::OFS_IRQ_STAT:
                rd[2:0] = st_r.regs.irq_stat;
            pif_pkg::OFS_IRQ_MASK:
                rd[2:0] = st_r.regs.irq_mask;
            default: begin
                hit = 1'b0;
            end
        endcase

        // Software writes first so that hardware sets below win.
        if (do_wr) begin
            case (avs_address)
                pif_pkg::OFS_REQ_FIRST:
                    st_nxt.regs.req_first = wb & pif_pkg::MASK_FIRST;
                pif_pkg::OFS_REQ_CMP:
                    st_nxt.regs.req_cmp = wb & pif_pkg::MASK_CMP;
                pif_pkg::OFS_EN_FIRST:
                    st_nxt.regs.en_first = wb & pif_pkg::MASK_FIRST;
                pif_pkg::OFS_EN_SECOND:
                    st_nxt.regs.en_second = wb & pif_pkg::MASK_CMP;
                pif_pkg::OFS_EN_THIRD:
                    st_nxt.regs.en_third = wb & pif_pkg::MASK_MOD;
                pif_pkg::OFS_CORE_CTRL:
                    st_nxt.regs.core_ctrl = wb & pif_pkg::MASK_CTRL;
                pif_pkg::OFS_IRQ_MASK:
                    st_nxt.regs.irq_mask = wb[2:0] & pif_pkg::MASK_STAT;
                default: begin
                end
            endcase
        end

        // Event edges set flags regardless of any enable bit.
        st_nxt.regs.req_first = st_nxt.regs.req_first | rise_first;
        if (rise_cmp) begin
            st_nxt.regs.req_cmp[pif_pkg::BIT_CMP] = 1'b1;
        end

        // Request is built from the registered flags and enables.
        // A new flag therefore raises the request one clock after it
        // becomes readable, which keeps the request path short.
        pend_first = st_r.regs.req_first & st_r.regs.en_first;
        pend_cmp = st_r.regs.req_cmp[pif_pkg::BIT_CMP]
            & st_r.regs.en_second[pif_pkg::BIT_CMP];
        pend_mod = st_r.mod_flags
            & st_r.regs.en_third[pif_pkg::BIT_MOD3:pif_pkg::BIT_MOD1];
        any_pend = (|pend_first) | pend_cmp | (|pend_mod);
        st_nxt.periph_req = any_pend;
        st_nxt.core_req = any_pend
            && st_r.regs.core_ctrl[pif_pkg::BIT_GIE]
            && st_r.regs.core_ctrl[pif_pkg::BIT_PERIPHERAL_IRQ_ENABLE];

        // Status events; read of the status clears it, set wins.
        // The read data hold the value from before this clock, so an event
        // that lands with the clearing read stays for the next read.
        new_flag = (|rise_first) | rise_cmp
            | (|src_edge.mod);
        ev = 3'h0;
        ev[pif_pkg::EV_FLAG] = new_flag;
        ev[pif_pkg::EV_RISE] = any_pend & ~st_r.periph_req;
        ev[pif_pkg::EV_FALL] = ~any_pend & st_r.periph_req;
        if (do_rd && avs_address == pif_pkg::OFS_IRQ_STAT) begin
            st_nxt.regs.irq_stat = ev;
        end else begin
            st_nxt.regs.irq_stat = st_r.regs.irq_stat | ev;
        end
        st_nxt.irq = |(st_nxt.regs.irq_stat & st_nxt.regs.irq_mask);

        // Bus answer one clock after the request is seen.
        // Answering from flops costs a second clock per access but keeps
        // waitrequest free of any path from the request inputs.
        case (st_r.bus)
            pif_pkg::BUS_IDLE: begin
                st_nxt.wait_n = 1'b0;
                if (avs_read || avs_write) begin
                    st_nxt.bus = pif_pkg::BUS_ANSWER;
                    st_nxt.wait_n = 1'b1;
                    st_nxt.rdata = avs_read ? rd : 32'h0000_0000;
                    st_nxt.resp = hit ? 2'h0 : 2'h2;
                end
            end
            pif_pkg::BUS_ANSWER: begin
                st_nxt.bus = pif_pkg::BUS_IDLE;
                st_nxt.wait_n = 1'b0;
            end
            default: begin
                st_nxt.bus = pif_pkg::BUS_IDLE;
                st_nxt.wait_n = 1'b0;
            end
        endcase
    end

    // =========================================================
    // Registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = ~st_r.wait_n;
    assign avs_response = st_r.resp;
    assign periph_irq_req = st_r.periph_req;
    assign core_irq_req = st_r.core_req;
    assign irq = st_r.irq;

endmodule

// File: common/pif_pkg.sv
// Package for the peripheral interrupt flag block: offsets, fields, resets.
// Assumes a 32-bit Avalon-MM slave with word addressing on byte offsets.
package pif_pkg;

    // =========================================================
    // Register byte offsets
    localparam logic [5:0] OFS_REQ_FIRST = 6'h00;
    localparam logic [5:0] OFS_REQ_CMP = 6'h04;
    localparam logic [5:0] OFS_REQ_MOD = 6'h08;
    localparam logic [5:0] OFS_EN_FIRST = 6'h0C;
    localparam logic [5:0] OFS_EN_SECOND = 6'h10;
    localparam logic [5:0] OFS_EN_THIRD = 6'h14;
    localparam logic [5:0] OFS_CORE_CTRL = 6'h18;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h1C;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h20;

    // =========================================================
    // Field positions and implemented-bit masks
    localparam int BIT_CMP = 5;
    localparam int BIT_MOD1 = 4;
    localparam int BIT_MOD2 = 5;
    localparam int BIT_MOD3 = 6;
    localparam int BIT_GIE = 7;
    localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
    localparam logic [7:0] MASK_FIRST = 8'hF3;
    localparam logic [7:0] MASK_CMP = 8'h20;
    localparam logic [7:0] MASK_MOD = 8'h70;
    localparam logic [7:0] MASK_CTRL = 8'hC0;
    localparam logic [2:0] MASK_STAT = 3'h7;

    // =========================================================
    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [2:0] RST_STAT = 3'h0;

    // Status event bits: new pending flag, request rose, request fell.
    localparam int EV_FLAG = 0;
    localparam int EV_RISE = 1;
    localparam int EV_FALL = 2;

    typedef struct packed {
        logic [7:0] req_first;
        logic [7:0] req_cmp;
        logic [7:0] en_first;
        logic [7:0] en_second;
        logic [7:0] en_third;
        logic [7:0] core_ctrl;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
    } pif_regs_t;

    typedef struct packed {
        logic [7:0] first;
        logic cmp;
        logic [2:0] mod;
    } pif_src_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ANSWER
    } pif_bus_st_t;

endpackage

// File: rtl/pif_sync.sv
// Two-flop synchroniser, one per bit, for asynchronous source levels.
// Assumes nothing reads the first stage but the second.
module pif_sync #(
    parameter int WIDTH = 12
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } pif_sync_st_t;

    pif_sync_st_t st_r;
    pif_sync_st_t st_nxt;

    always_comb begin
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.s2;

endmodule

// File: testbench/pif_checker.sv
// Port-level checks for the interrupt flag block.
// Assumes a bus master that holds each request until it is answered.
module pif_checker (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire logic [2:0] modulator_pending_src,
    input wire logic periph_irq_req,
    input wire logic core_irq_req,
    input wire logic irq
);
    // ==========================================================
    // Properties
    logic ans;
    assign ans = avs_read && !avs_waitrequest;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    chk_rst_quiet: assert property ($fell(sys_rst) |->
        !periph_irq_req && !core_irq_req && !irq) else $error("reset");
    chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("long answer");
    chk_answer_due: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
    chk_high_zero: assert property (ans |->
        avs_readdata[31:8] == 24'h0) else $error("upper bits");
    chk_cmp_spare: assert property (ans &&
        avs_address == pif_pkg::OFS_REQ_CMP |->
        avs_readdata[7:0] == (avs_readdata[7:0] & 8'h20)) else $error("cmp");
    chk_mod_spare: assert property (ans &&
        avs_address == pif_pkg::OFS_REQ_MOD |->
        avs_readdata[7:0] == (avs_readdata[7:0] & 8'h70)) else $error("mod");
    chk_mod_follow: assert property (ans &&
        avs_address == pif_pkg::OFS_REQ_MOD &&
        $past(modulator_pending_src, 6) == modulator_pending_src |->
        avs_readdata[6:4] == modulator_pending_src) else $error("follow");
    chk_bad_addr: assert property (!avs_waitrequest && avs_address > 6'h20
        |-> avs_response == 2'h2) else $error("unmapped");
    chk_ok_resp: assert property (ans &&
        avs_address == pif_pkg::OFS_REQ_FIRST |->
        avs_response == 2'h0) else $error("mapped read not OK");
    chk_core_gate: assert property (core_irq_req |-> periph_irq_req)
        else $error("core request alone");
endmodule

bind pif_top pif_checker u_chk (.*);

// File: testbench/pif_periph_model.sv
// Peripheral side: event levels and the modulators' own flags.
// Assumes callers enter its tasks just after a rising clock edge.
module pif_periph_model (
    input wire logic sys_clk,
    output logic [7:0] evt_first,
    output logic evt_comparator,
    output logic [2:0] modulator_pending_src
);
    // ==========================================================
    // Sources
    initial begin
        evt_first = 8'h00;
        evt_comparator = 1'h0;
        modulator_pending_src = 3'h0;
    end
    // Held four clocks so the two-flop synchroniser cannot miss it.
    task automatic fire(input logic [7:0] f, input logic c);
        evt_first <= f;
        evt_comparator <= c;
        repeat (4) @(posedge sys_clk);
        evt_first <= 8'h00;
        evt_comparator <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic set_mod(input logic [2:0] m);
        modulator_pending_src <= m;
        repeat (8) @(posedge sys_clk);
    endtask
endmodule

// File: testbench/pif_top_tb.sv
// Self-checking bench for the interrupt flag block.
// Assumes one answer per request, one cycle after it is taken.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("ERROR %0t got %h want %h", $time, g, e); end end
module pif_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk;
    logic sys_rst;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic [7:0] evt_first;
    logic evt_comparator;
    logic [2:0] modulator_pending_src;
    logic periph_irq_req;
    logic core_irq_req;
    logic irq;
    logic [7:0] rd_q;
    logic [1:0] rs_q;
    int bad_count;
    int n_checks;
    pif_top uut (.*);
    pif_periph_model pm (.*);
    // ==========================================================
    // Bus tasks
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 40);
        if (avs_waitrequest !== 1'h0) begin
            bad_count++;
            summarize();
        end
        rd_q = avs_readdata[7:0];
        rs_q = avs_response;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        bus(1'h0, a, 8'h00);
        `CHK(rd_q, e)
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        for (int a = 0; a <= 32; a += 4) begin
            rchk(6'(a), 8'h00);
        end
        `CHK(rs_q, 2'h0)
        bus(1'h1, 6'h24, 8'hFF);
        `CHK(rs_q, 2'h2)
    endtask
    task automatic t_flags;
        pm.fire(8'hFF, 1'h1);
        rchk(pif_pkg::OFS_REQ_FIRST, 8'hF3);
        rchk(pif_pkg::OFS_REQ_CMP, 8'h20);
        `CHK(periph_irq_req, 1'h0)
        rchk(pif_pkg::OFS_IRQ_STAT, 8'h01);
        rchk(pif_pkg::OFS_IRQ_STAT, 8'h00);
        bus(1'h1, pif_pkg::OFS_REQ_FIRST, 8'h00);
        bus(1'h1, pif_pkg::OFS_REQ_CMP, 8'h00);
        rchk(pif_pkg::OFS_REQ_FIRST, 8'h00);
    endtask
    task automatic t_enable;
        bus(1'h1, pif_pkg::OFS_EN_FIRST, 8'hFF);
        bus(1'h1, pif_pkg::OFS_EN_THIRD, 8'hFF);
        bus(1'h1, pif_pkg::OFS_CORE_CTRL, 8'hFF);
        bus(1'h1, pif_pkg::OFS_IRQ_MASK, 8'hFF);
        rchk(pif_pkg::OFS_EN_FIRST, 8'hF3);
        rchk(pif_pkg::OFS_EN_THIRD, 8'h70);
        rchk(pif_pkg::OFS_CORE_CTRL, 8'hC0);
        pm.fire(8'h01, 1'h0);
        `CHK({periph_irq_req, core_irq_req, irq}, 3'h7)
        rchk(pif_pkg::OFS_IRQ_STAT, 8'h03);
        bus(1'h1, pif_pkg::OFS_REQ_FIRST, 8'h00);
        `CHK(periph_irq_req, 1'h0)
        bus(1'h1, pif_pkg::OFS_IRQ_MASK, 8'h00);
        `CHK(irq, 1'h0)
        rchk(pif_pkg::OFS_IRQ_STAT, 8'h04);
    endtask
    task automatic t_mod;
        pm.set_mod(3'h5);
        rchk(pif_pkg::OFS_REQ_MOD, 8'h50);
        `CHK(periph_irq_req, 1'h1)
        bus(1'h1, pif_pkg::OFS_CORE_CTRL, 8'h80);
        `CHK({periph_irq_req, core_irq_req}, 2'h2)
        bus(1'h1, pif_pkg::OFS_REQ_MOD, 8'h00);
        rchk(pif_pkg::OFS_REQ_MOD, 8'h50);
        pm.set_mod(3'h2);
        rchk(pif_pkg::OFS_REQ_MOD, 8'h20);
        pm.set_mod(3'h0);
        rchk(pif_pkg::OFS_REQ_MOD, 8'h00);
    endtask
    task automatic t_lanes;
        avs_byteenable <= 4'hE;
        bus(1'h1, pif_pkg::OFS_EN_FIRST, 8'h00);
        avs_byteenable <= 4'hF;
        rchk(pif_pkg::OFS_EN_FIRST, 8'hF3);
    endtask
    task automatic t_rerst;
        pm.fire(8'h02, 1'h1);
        `CHK(periph_irq_req, 1'h1)
        sys_rst <= 1'h1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'h0;
        @(posedge sys_clk);
        `CHK({periph_irq_req, core_irq_req, irq}, 3'h0)
        rchk(pif_pkg::OFS_REQ_FIRST, 8'h00);
        rchk(pif_pkg::OFS_REQ_CMP, 8'h00);
        rchk(pif_pkg::OFS_EN_FIRST, 8'h00);
    endtask
    initial begin
        sys_rst = 1'h1;
        avs_address = 6'h00;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'h0;
        @(posedge sys_clk);
        t_reset();
        t_flags();
        t_enable();
        t_mod();
        t_lanes();
        t_rerst();
        summarize();
    end
endmodule
